/* src/aes_dp_pkg.sv */
/*
 Shared constants: register offsets, fields, reset values, timing.
 Assumes byte-wide registers on an 8-bit address space.
*/
package aes_dp_pkg;
    // ************
    // device register offsets
    // ************
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'hE0;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'hE1;
    localparam logic [7:0] ADDR_BLOCK_CONFIG = 8'hE9;
    localparam logic [7:0] ADDR_DATA_PATH_CONFIG = 8'hEA;
    localparam logic [7:0] ADDR_BLOCK_INPUT = 8'hEB;
    localparam logic [7:0] ADDR_MIX_OPERAND_INPUT = 8'hEC;
    localparam logic [7:0] ADDR_KEY_BYTE_INPUT = 8'hED;
    localparam logic [7:0] ADDR_CIPHER_OUTPUT_BYTE = 8'hF5;
    // ************
    // field positions and reset values
    // ************
    localparam int MIX_EN_BIT = 0;
    localparam int OUT_SEL_LSB = 1;
    localparam int KEY_LEN_LSB = 0;
    localparam int DIR_BIT = 2;
    localparam int ENABLE_BIT = 3;
    localparam int BUSY_BIT = 4;
    localparam int DONE_BIT = 5;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] OUT_RAW = 2'h0;
    localparam logic [1:0] OUT_MIXED = 2'h1;
    localparam logic [1:0] OUT_INV_KEY = 2'h2;
    // ************
    // block sizes and operation times in clocks
    // ************
    localparam logic [4:0] BLOCK_BYTES = 5'h10;
    localparam logic [5:0] KEY_BYTES_128 = 6'h10;
    localparam logic [5:0] KEY_BYTES_192 = 6'h18;
    localparam logic [5:0] KEY_BYTES_256 = 6'h20;
    localparam logic [8:0] OP_CLOCKS_128 = 9'd218;
    localparam logic [8:0] OP_CLOCKS_192 = 9'd274;
    localparam logic [8:0] OP_CLOCKS_256 = 9'd298;
    // ************
    // host register offsets and command bits
    // ************
    localparam logic [3:0] HADDR_BIN_STAGE = 4'h0;
    localparam logic [3:0] HADDR_XIN_STAGE = 4'h1;
    localparam logic [3:0] HADDR_KIN_STAGE = 4'h2;
    localparam logic [3:0] HADDR_RAW_ADDR = 4'h3;
    localparam logic [3:0] HADDR_RAW_DATA = 4'h4;
    localparam logic [3:0] HADDR_COMMAND = 4'h5;
    localparam logic [3:0] HADDR_STATUS = 4'h6;
    localparam logic [3:0] HADDR_MASK = 4'h7;
    localparam logic [3:0] HADDR_FETCHED = 4'h8;
    localparam int CMD_PUSH = 0;
    localparam int CMD_FETCH = 1;
    localparam int CMD_FETCH_MIX = 2;
    localparam int CMD_RAW_WRITE = 3;
    localparam int CMD_RAW_READ = 4;
endpackage

/* src/aes_dp_if.sv */
/*
 Register bus joining the byte source (firmware or DMA) to the device.
 Assumes one clock; read data stand the cycle after the read strobe.
*/
`timescale 1ns/100ps
`default_nettype none
interface aes_dp_if;
    logic [7:0] regAddr;
    logic [7:0] regWdata;
    logic regWr;
    logic regRd;
    logic [7:0] regRdata;
    modport dev (input regAddr, input regWdata, input regWr, input regRd,
        output regRdata);
    modport src (output regAddr, output regWdata, output regWr,
        output regRd, input regRdata);
endinterface
`default_nettype wire

/* src/aes_dp_device.sv */
/*
 Device end: config, block, operand and key byte registers, byte
 sequencing, operation timer, output selection, completion interrupt.
 No cipher rounds: a stand-in result (input byte xor key byte) keeps
 the output path alive.
 Assumes the byte source keeps to the write order below.
*/
//
// Contract
// R1: bits 2:1 choose output byte source
// R2: 00 raw, 01 xor operand, 10 inverse key
// R3: mix enabled feeds input xor operand
// R4: mix disabled passes block input unchanged
// R5: encryption plaintext comes through block input
// R6: decryption ciphertext comes through block input
// R7: key inversion loads key via block input; code takes the inverse-key output from bytes loaded via key byte input
// R8: DMA writes accepted as ordinary register loads
// R9: firmware writes block, operand, key in order
// R10: block and operand read back last written
// R11: operand serves input and output xor paths
// R12: done set at finish, software clears
// R13: enable starts, clearing resets whole unit; code clears only byte indices, busy and timer
// R14: operation takes 218, 274 or 298 clocks
// R15: write operand before each mixed output read
// R16: config bits 7:3 read zero, ignore writes
// R17: key bytes collected in order by size
`timescale 1ns/100ps
`default_nettype none
module aes_dp_device
    import aes_dp_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // register bus
    aes_dp_if.dev bus,
    // user side
    output logic irq,
    output logic busy
);
    // ************
    // state
    // ************
    logic [1:0] output_source_select_ff;
    logic mixEn_ff;
    logic [7:0] blockIn_ff;
    logic [7:0] mixIn_ff;
    logic [7:0] keyIn_ff;
    logic [1:0] keyLen_ff;
    logic dir_ff;
    logic enable_ff;
    logic busy_ff;
    logic done_ff;
    logic irqStat_ff;
    logic irqMask_ff;
    logic irq_ff;
    logic [4:0] inIdx_ff;
    logic [5:0] keyIdx_ff;
    logic [3:0] outIdx_ff;
    logic [8:0] cnt_ff;
    logic [7:0] rdata_ff;
    logic [7:0] blockMem [16];
    logic [7:0] keyMem [32];

    // ************
    // decode
    // ************
    wire logic wrStatus = bus.regWr && bus.regAddr == ADDR_IRQ_STATUS;
    wire logic wrMask = bus.regWr && bus.regAddr == ADDR_IRQ_MASK;
    wire logic wrBcfg = bus.regWr && bus.regAddr == ADDR_BLOCK_CONFIG;
    wire logic wrDcfg = bus.regWr && bus.regAddr == ADDR_DATA_PATH_CONFIG;
    wire logic wrBin = bus.regWr && bus.regAddr == ADDR_BLOCK_INPUT;
    wire logic wrXin = bus.regWr && bus.regAddr == ADDR_MIX_OPERAND_INPUT;
    wire logic wrKin = bus.regWr && bus.regAddr == ADDR_KEY_BYTE_INPUT;
    wire logic rdOut = bus.regRd && bus.regAddr == ADDR_CIPHER_OUTPUT_BYTE;
    wire logic unitOff = wrBcfg && !bus.regWdata[ENABLE_BIT];
    wire logic [5:0] keyLen = (keyLen_ff == 2'h1) ? KEY_BYTES_192 :
        (keyLen_ff == 2'h2) ? KEY_BYTES_256 : KEY_BYTES_128; // see R17
    wire logic [8:0] opClocks = (keyLen_ff == 2'h1) ? OP_CLOCKS_192 :
        (keyLen_ff == 2'h2) ? OP_CLOCKS_256 : OP_CLOCKS_128; // see R14
    // core input byte, taken when the key byte closes a group
    wire logic [7:0] coreIn = mixEn_ff ? (blockIn_ff ^ mixIn_ff)
        : blockIn_ff; // see R3, R4
    wire logic takeGroup = wrKin && !busy_ff && inIdx_ff < BLOCK_BYTES;
    wire logic takeKey = wrKin && !busy_ff && keyIdx_ff < keyLen;
    wire logic start = enable_ff && !busy_ff && inIdx_ff == BLOCK_BYTES
        && keyIdx_ff == keyLen; // see R13
    wire logic finish = busy_ff && cnt_ff == 9'd1;
    wire logic [7:0] resultByte = blockMem[outIdx_ff] ^ keyMem[outIdx_ff];
    wire logic [7:0] outByte = (output_source_select_ff == OUT_RAW) ? resultByte :
        (output_source_select_ff == OUT_MIXED) ? (resultByte ^ mixIn_ff) :
        (output_source_select_ff == OUT_INV_KEY) ? keyMem[outIdx_ff] : RESET_BYTE;
    wire logic [7:0] bcfgRead = {2'h0, done_ff, busy_ff, enable_ff, dir_ff,
        keyLen_ff};
    wire logic [7:0] dcfgRead = {5'h00, output_source_select_ff, mixEn_ff}; // see R16
    wire logic [7:0] readByte =
        (bus.regAddr == ADDR_IRQ_STATUS) ? {7'h00, irqStat_ff} :
        (bus.regAddr == ADDR_IRQ_MASK) ? {7'h00, irqMask_ff} :
        (bus.regAddr == ADDR_BLOCK_CONFIG) ? bcfgRead :
        (bus.regAddr == ADDR_DATA_PATH_CONFIG) ? dcfgRead :
        (bus.regAddr == ADDR_BLOCK_INPUT) ? blockIn_ff :
        (bus.regAddr == ADDR_MIX_OPERAND_INPUT) ? mixIn_ff :
        (bus.regAddr == ADDR_KEY_BYTE_INPUT) ? keyIn_ff :
        (bus.regAddr == ADDR_CIPHER_OUTPUT_BYTE) ? outByte : RESET_BYTE;

    assign bus.regRdata = rdata_ff;
    assign irq = irq_ff;
    assign busy = busy_ff;

    // ************
    // configuration and byte registers
    // ************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            output_source_select_ff <= 2'h0;
            mixEn_ff <= 1'b0;
            blockIn_ff <= RESET_BYTE;
            mixIn_ff <= RESET_BYTE;
            keyIn_ff <= RESET_BYTE;
            keyLen_ff <= 2'h0;
            dir_ff <= 1'b0;
            enable_ff <= 1'b0;
        end else begin
            if (wrDcfg) begin
                output_source_select_ff <= bus.regWdata[OUT_SEL_LSB +: 2]; // see R1, R2
                mixEn_ff <= bus.regWdata[MIX_EN_BIT];
            end
            // DMA and firmware loads look alike here
            if (wrBin) begin
                blockIn_ff <= bus.regWdata; // see R8, R10
            end
            if (wrXin) begin
                mixIn_ff <= bus.regWdata; // see R10, R11
            end
            if (wrKin) begin
                keyIn_ff <= bus.regWdata;
            end
            if (wrBcfg) begin
                keyLen_ff <= bus.regWdata[KEY_LEN_LSB +: 2];
                dir_ff <= bus.regWdata[DIR_BIT];
                enable_ff <= bus.regWdata[ENABLE_BIT];
            end
        end
    end

    // ************
    // sequencing, timer and flags
    // ************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            inIdx_ff <= 5'h00;
            keyIdx_ff <= 6'h00;
            outIdx_ff <= 4'h0;
            busy_ff <= 1'b0;
            cnt_ff <= 9'h000;
        end else if (unitOff) begin
            inIdx_ff <= 5'h00; // see R13
            keyIdx_ff <= 6'h00;
            outIdx_ff <= 4'h0;
            busy_ff <= 1'b0;
            cnt_ff <= 9'h000;
        end else begin
            if (takeGroup) begin
                inIdx_ff <= inIdx_ff + 5'h01; // see R9
            end
            if (takeKey) begin
                keyIdx_ff <= keyIdx_ff + 6'h01; // see R17
            end
            if (start) begin
                busy_ff <= 1'b1;
                cnt_ff <= opClocks; // see R14
                outIdx_ff <= 4'h0;
            end else if (finish) begin
                busy_ff <= 1'b0;
                cnt_ff <= 9'h000;
                inIdx_ff <= 5'h00;
                keyIdx_ff <= 6'h00;
            end else if (busy_ff) begin
                cnt_ff <= cnt_ff - 9'h001;
            end
            if (rdOut && !busy_ff) begin
                outIdx_ff <= outIdx_ff + 4'h1; // see R15
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (takeGroup) begin
            blockMem[inIdx_ff[3:0]] <= coreIn; // see R5, R6, R7
        end
        if (takeKey) begin
            keyMem[keyIdx_ff[4:0]] <= bus.regWdata;
        end
    end

    // set wins over every clear
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            done_ff <= 1'b0;
            irqStat_ff <= 1'b0;
            irqMask_ff <= 1'b0;
            irq_ff <= 1'b0;
            rdata_ff <= RESET_BYTE;
        end else begin
            if (finish) begin
                done_ff <= 1'b1; // see R12
            end else if (wrBcfg) begin
                done_ff <= bus.regWdata[DONE_BIT];
            end
            if (finish) begin
                irqStat_ff <= 1'b1;
            end else if (wrStatus && bus.regWdata[0]) begin
                irqStat_ff <= 1'b0;
            end
            if (wrMask) begin
                irqMask_ff <= bus.regWdata[0];
            end
            irq_ff <= (irqStat_ff || finish) && irqMask_ff;
            if (bus.regRd) begin
                rdata_ff <= readByte;
            end
        end
    end
endmodule
`default_nettype wire

/* src/aes_dp_source.sv */
/*
 Byte source end: drives the device bus in group order on command
 from software through its own registers.
 Assumes read data one cycle after each read strobe.
*/
`timescale 1ns/100ps
`default_nettype none
module aes_dp_source
    import aes_dp_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // device bus
    aes_dp_if.src bus,
    // software port
    input wire logic [3:0] swAddr,
    input wire logic [7:0] swWdata,
    input wire logic swWr,
    input wire logic swRd,
    output logic [7:0] swRdata,
    output logic irq
);
    typedef enum logic [2:0] {S_IDLE, S_XIN, S_KIN, S_END, S_RD, S_WAIT,
        S_CAP} seq_t;

    // ************
    // state
    // ************
    seq_t state_ff;
    logic [7:0] binStage_ff;
    logic [7:0] xinStage_ff;
    logic [7:0] kinStage_ff;
    logic [7:0] rawAddr_ff;
    logic [7:0] rawData_ff;
    logic [7:0] fetched_ff;
    logic [1:0] stat_ff;
    logic [1:0] mask_ff;
    logic irq_ff;
    logic [7:0] swRdata_ff;
    logic [7:0] addr_ff;
    logic [7:0] wdata_ff;
    logic wr_ff;
    logic rd_ff;

    // ************
    // decode
    // ************
    wire logic idle = state_ff == S_IDLE;
    wire logic cmdWr = swWr && swAddr == HADDR_COMMAND && idle;
    wire logic doPush = cmdWr && swWdata[CMD_PUSH];
    wire logic doFetch = cmdWr && swWdata[CMD_FETCH];
    wire logic doFetchMix = cmdWr && swWdata[CMD_FETCH_MIX];
    wire logic doRawWr = cmdWr && swWdata[CMD_RAW_WRITE];
    wire logic doRawRd = cmdWr && swWdata[CMD_RAW_READ];
    wire logic seqDone = state_ff == S_END;
    wire logic readDone = state_ff == S_CAP;
    wire logic clrStat = swWr && swAddr == HADDR_STATUS;
    wire logic [7:0] swRead =
        (swAddr == HADDR_BIN_STAGE) ? binStage_ff :
        (swAddr == HADDR_XIN_STAGE) ? xinStage_ff :
        (swAddr == HADDR_KIN_STAGE) ? kinStage_ff :
        (swAddr == HADDR_RAW_ADDR) ? rawAddr_ff :
        (swAddr == HADDR_RAW_DATA) ? rawData_ff :
        (swAddr == HADDR_COMMAND) ? {7'h00, !idle} :
        (swAddr == HADDR_STATUS) ? {6'h00, stat_ff} :
        (swAddr == HADDR_MASK) ? {6'h00, mask_ff} :
        (swAddr == HADDR_FETCHED) ? fetched_ff : RESET_BYTE;

    assign bus.regAddr = addr_ff;
    assign bus.regWdata = wdata_ff;
    assign bus.regWr = wr_ff;
    assign bus.regRd = rd_ff;
    assign swRdata = swRdata_ff;
    assign irq = irq_ff;

    // ************
    // software registers
    // ************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            binStage_ff <= RESET_BYTE;
            xinStage_ff <= RESET_BYTE;
            kinStage_ff <= RESET_BYTE;
            rawAddr_ff <= RESET_BYTE;
            rawData_ff <= RESET_BYTE;
            mask_ff <= 2'h0;
            swRdata_ff <= RESET_BYTE;
        end else begin
            if (swWr && swAddr == HADDR_BIN_STAGE) begin
                binStage_ff <= swWdata;
            end
            if (swWr && swAddr == HADDR_XIN_STAGE) begin
                xinStage_ff <= swWdata;
            end
            if (swWr && swAddr == HADDR_KIN_STAGE) begin
                kinStage_ff <= swWdata;
            end
            if (swWr && swAddr == HADDR_RAW_ADDR) begin
                rawAddr_ff <= swWdata;
            end
            if (swWr && swAddr == HADDR_RAW_DATA) begin
                rawData_ff <= swWdata;
            end
            if (swWr && swAddr == HADDR_MASK) begin
                mask_ff <= swWdata[1:0];
            end
            if (swRd) begin
                swRdata_ff <= swRead;
            end
        end
    end

    // set wins over write-one-to-clear
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            stat_ff <= 2'h0;
            irq_ff <= 1'b0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == 0) ? seqDone : readDone) begin
                    stat_ff[i] <= 1'b1;
                end else if (clrStat && swWdata[i]) begin
                    stat_ff[i] <= 1'b0;
                end
            end
            irq_ff <= |(stat_ff & mask_ff);
        end
    end

    // ************
    // bus sequencer
    // ************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= S_IDLE;
            addr_ff <= RESET_BYTE;
            wdata_ff <= RESET_BYTE;
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            fetched_ff <= RESET_BYTE;
        end else begin
            unique case (state_ff)
                S_IDLE: begin
                    wr_ff <= 1'b0;
                    rd_ff <= 1'b0;
                    if (doPush) begin
                        wr_ff <= 1'b1; // see R5, R6, R7, R8
                        addr_ff <= ADDR_BLOCK_INPUT;
                        wdata_ff <= binStage_ff;
                        state_ff <= S_XIN;
                    end else if (doFetchMix) begin
                        wr_ff <= 1'b1; // see R15
                        addr_ff <= ADDR_MIX_OPERAND_INPUT;
                        wdata_ff <= xinStage_ff;
                        state_ff <= S_RD;
                    end else if (doFetch) begin
                        rd_ff <= 1'b1;
                        addr_ff <= ADDR_CIPHER_OUTPUT_BYTE;
                        state_ff <= S_WAIT;
                    end else if (doRawWr) begin
                        wr_ff <= 1'b1;
                        addr_ff <= rawAddr_ff;
                        wdata_ff <= rawData_ff;
                        state_ff <= S_END;
                    end else if (doRawRd) begin
                        rd_ff <= 1'b1;
                        addr_ff <= rawAddr_ff;
                        state_ff <= S_WAIT;
                    end
                end
                S_XIN: begin
                    addr_ff <= ADDR_MIX_OPERAND_INPUT; // see R9
                    wdata_ff <= xinStage_ff;
                    state_ff <= S_KIN;
                end
                S_KIN: begin
                    addr_ff <= ADDR_KEY_BYTE_INPUT; // see R9
                    wdata_ff <= kinStage_ff;
                    state_ff <= S_END;
                end
                S_END: begin
                    wr_ff <= 1'b0;
                    state_ff <= S_IDLE;
                end
                S_RD: begin
                    wr_ff <= 1'b0;
                    rd_ff <= 1'b1;
                    addr_ff <= ADDR_CIPHER_OUTPUT_BYTE;
                    state_ff <= S_WAIT;
                end
                S_WAIT: begin
                    rd_ff <= 1'b0;
                    state_ff <= S_CAP;
                end
                S_CAP: begin
                    fetched_ff <= bus.regRdata;
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* verification/aes_dp_asserts.sv */
/*
 Checks on the joining bus, irq and busy.
 Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/100ps
`default_nettype none
module aes_dp_asserts
    import aes_dp_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // register bus
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdata,
    // device outputs
    input wire logic irq,
    input wire logic busy
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    // ************
    // shadow copies of written registers
    // ************
    logic [7:0] lastBin_ff, lastXin_ff, cfg_ff, mask_ff;
    logic [8:0] busyCnt_ff;
    wire logic wrBin = regWr && (regAddr == ADDR_BLOCK_INPUT);
    wire logic wrXin = regWr && (regAddr == ADDR_MIX_OPERAND_INPUT);
    wire logic wrCfg = regWr && (regAddr == ADDR_BLOCK_CONFIG);
    wire logic wrMask = regWr && (regAddr == ADDR_IRQ_MASK);
    wire logic wrStop = wrCfg && !regWdata[ENABLE_BIT];
    wire logic wrClr = regWr && (regAddr == ADDR_IRQ_STATUS) && regWdata[0];
    wire logic rdCfg = regRd && (regAddr == ADDR_DATA_PATH_CONFIG);
    wire logic rdBin = regRd && (regAddr == ADDR_BLOCK_INPUT);
    wire logic rdXin = regRd && (regAddr == ADDR_MIX_OPERAND_INPUT);
    wire logic mapped = regAddr inside {ADDR_IRQ_STATUS, ADDR_IRQ_MASK,
        [ADDR_BLOCK_CONFIG:ADDR_KEY_BYTE_INPUT], ADDR_CIPHER_OUTPUT_BYTE};
    wire logic rdHole = regRd && !mapped;
    wire logic enOn = cfg_ff[ENABLE_BIT];
    wire logic [8:0] opLen = (cfg_ff[1:0] == 2'h1) ? OP_CLOCKS_192 :
        (cfg_ff[1:0] == 2'h2) ? OP_CLOCKS_256 : OP_CLOCKS_128;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            lastBin_ff <= RESET_BYTE;
            lastXin_ff <= RESET_BYTE;
            cfg_ff <= RESET_BYTE;
            mask_ff <= RESET_BYTE;
        end else begin
            if (wrBin) lastBin_ff <= regWdata;
            if (wrXin) lastXin_ff <= regWdata;
            if (wrCfg) cfg_ff <= regWdata;
            if (wrMask) mask_ff <= regWdata;
        end
    end
    // length of the current busy stretch
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) busyCnt_ff <= 9'h000;
        else busyCnt_ff <= busy ? busyCnt_ff + 9'h001 : 9'h000;
    end
    // ************
    // properties
    // ************
    sequence binWrite;
        wrBin;
    endsequence
    sequence xinWrite;
        wrXin;
    endsequence
    property groupOrder;
        binWrite ##1 xinWrite |=> regWr && regAddr == ADDR_KEY_BYTE_INPUT;
    endproperty
    property opLength;
        $fell(busy) && enOn |-> busyCnt_ff == opLen;
    endproperty
    property doneIrq;
        $fell(busy) && enOn && mask_ff[0] |=> irq;
    endproperty
    AST_STROBES_APART: assert property (!(regWr && regRd))
        else $error("strobes together");
    AST_GROUP_ORDER: assert property (groupOrder)
        else $error("group order broken");
    AST_CFG_ZERO: assert property (rdCfg |=> !(|regRdata[7:3]))
        else $error("config upper bits not zero");
    AST_UNMAPPED: assert property (rdHole |=> regRdata == 8'h00)
        else $error("unmapped read not zero");
    AST_BIN_BACK: assert property (rdBin |=> regRdata == lastBin_ff)
        else $error("block readback");
    AST_XIN_BACK: assert property (rdXin |=> regRdata == lastXin_ff)
        else $error("operand readback");
    AST_OP_LEN: assert property (opLength)
        else $error("operation length wrong");
    AST_DONE_IRQ: assert property (doneIrq)
        else $error("no irq after completion");
    AST_IRQ_CLEAR: assert property (wrClr && !busy |-> ##2 !irq)
        else $error("irq after clear");
    AST_MASKED: assert property (!mask_ff[0] |=> !irq)
        else $error("irq while masked");
    AST_ABORT: assert property (wrStop |=> !busy [*2])
        else $error("busy after stop");
    AST_START_EN: assert property ($rose(busy) |-> enOn)
        else $error("start while disabled");
    cover property ($fell(busy) && enOn);
endmodule
`default_nettype wire

/* verification/test_aes_data_path_inputs.sv */
/*
 Bench: source and device driven through the software port.
 Assumes package, interface, ends and checker compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin \
    totalChecks++; \
    if ((g) !== (e)) begin \
        errCount++; \
        $display("wrong value %s exp %h got %h", n, e, g); \
    end \
end
module test_aes_data_path_inputs
    import aes_dp_pkg::*;
;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] swAddr = 4'h0;
    logic [7:0] swWdata = 8'h00;
    logic swWr = 1'b0, swRd = 1'b0;
    logic [7:0] swRdata, rd, x;
    logic srcIrq, devIrq, busy;
    logic [31:0] rnd = 32'h8AE5;
    logic [7:0] bArr [16], xArr [16], kArr [16];
    int errCount = 0, totalChecks = 0, cycles = 0;
    aes_dp_if bus ();
    aes_dp_device aes_dp_device_i (.core_clk(core_clk), .rstn(rstn),
        .bus(bus), .irq(devIrq), .busy(busy));
    aes_dp_source aes_dp_source_i (.core_clk(core_clk), .rstn(rstn),
        .bus(bus), .swAddr(swAddr), .swWdata(swWdata), .swWr(swWr),
        .swRd(swRd), .swRdata(swRdata), .irq(srcIrq));
    aes_dp_asserts aes_dp_asserts_i (.core_clk(core_clk), .rstn(rstn),
        .regAddr(bus.regAddr), .regWdata(bus.regWdata), .regWr(bus.regWr),
        .regRd(bus.regRd), .regRdata(bus.regRdata), .irq(devIrq),
        .busy(busy));
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errCount++;
            endSim();
        end
    end
    // ************
    // tasks
    // ************
    task automatic endSim();
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    function automatic logic [7:0] roll();
        rnd = {rnd[30:0], 1'b0} ^ (rnd[31] ? 32'h04C11DB7 : 32'h00000000);
        return rnd[7:0];
    endfunction
    function automatic logic [7:0] expOut(input int i, input logic [1:0] sel,
        input logic mix, input logic [7:0] xo);
        logic [7:0] r;
        r = (mix ? bArr[i] ^ xArr[i] : bArr[i]) ^ kArr[i];
        return sel == 2'h0 ? r : sel == 2'h1 ? r ^ xo :
            sel == 2'h2 ? kArr[i] : 8'h00;
    endfunction
    task automatic swWrite(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        swAddr <= a;
        swWdata <= d;
        swWr <= 1'b1;
        @(posedge core_clk);
        swWr <= 1'b0;
    endtask
    task automatic swRead(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        swAddr <= a;
        swRd <= 1'b1;
        @(posedge core_clk);
        swRd <= 1'b0;
        #1 d = swRdata;
    endtask
    task automatic cmd(input logic [7:0] c);
        int n;
        swWrite(HADDR_COMMAND, c);
        n = 0;
        while (srcIrq !== 1'b1 && n < 50) begin
            @(posedge core_clk);
            #1 n++;
        end
        `CHK("source irq", 1'b1, srcIrq)
        swWrite(HADDR_STATUS, 8'h03);
        repeat (2) @(posedge core_clk);
    endtask
    task automatic rawWr(input logic [7:0] a, input logic [7:0] d);
        swWrite(HADDR_RAW_ADDR, a);
        swWrite(HADDR_RAW_DATA, d);
        cmd(8'h01 << CMD_RAW_WRITE);
    endtask
    task automatic rawRd(input logic [7:0] a, output logic [7:0] d);
        swWrite(HADDR_RAW_ADDR, a);
        cmd(8'h01 << CMD_RAW_READ);
        swRead(HADDR_FETCHED, d);
    endtask
    task automatic runOp(input logic mix, logic [1:0] ks, bit stop);
        int n;
        rawWr(ADDR_DATA_PATH_CONFIG, {7'h00, mix});
        rawWr(ADDR_BLOCK_CONFIG, {4'h0, 2'h3, ks});
        for (int i = 0; i < 16; i++) begin
            bArr[i] = roll();
            xArr[i] = roll();
            kArr[i] = roll();
            if (i == 0) xArr[i] = 8'hFF;
            swWrite(HADDR_BIN_STAGE, bArr[i]);
            swWrite(HADDR_XIN_STAGE, xArr[i]);
            swWrite(HADDR_KIN_STAGE, kArr[i]);
            cmd(8'h01 << CMD_PUSH);
        end
        `CHK("busy after groups", 1'(ks == 2'h0), busy)
        for (int i = 0; i < (ks == 2'h1 ? 8 : ks == 2'h2 ? 16 : 0); i++)
            rawWr(ADDR_KEY_BYTE_INPUT, 8'h5A);
        `CHK("busy", 1'b1, busy)
        if (stop) begin
            rawWr(ADDR_BLOCK_CONFIG, 8'h04);
            `CHK("busy", 1'b0, busy)
            rawRd(ADDR_BLOCK_CONFIG, rd);
            `CHK("block config", 8'h04, rd)
            return;
        end
        n = 0;
        while (busy !== 1'b0 && n < 400) begin
            @(posedge core_clk);
            #1 n++;
        end
        @(posedge core_clk);
        #1 `CHK("device irq", 1'b1, devIrq)
        rawRd(ADDR_BLOCK_CONFIG, rd);
        `CHK("block config", {4'h2, 2'h3, ks}, rd)
        for (int i = 0; i < 16; i++) begin
            rawWr(ADDR_DATA_PATH_CONFIG, {5'h00, 2'(i % 4), mix});
            x = roll();
            if (i % 4 == 1) begin
                swWrite(HADDR_XIN_STAGE, x);
                cmd(8'h01 << CMD_FETCH_MIX);
            end else cmd(8'h01 << CMD_FETCH);
            swRead(HADDR_FETCHED, rd);
            `CHK("output byte", expOut(i, 2'(i % 4), mix, x), rd)
        end
        rawWr(ADDR_IRQ_MASK, 8'h00);
        `CHK("device irq", 1'b0, devIrq)
        rawWr(ADDR_IRQ_MASK, 8'h01);
        rawWr(ADDR_IRQ_STATUS, 8'h01);
        `CHK("device irq", 1'b0, devIrq)
    endtask
    // ************
    // main sequence
    // ************
    initial begin
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        swWrite(HADDR_MASK, 8'h03);
        for (int a = 8'hE9; a <= 8'hED; a++) begin
            rawRd(8'(a), rd);
            `CHK("reset value", 8'h00, rd)
        end
        rawRd(8'h80, rd);
        `CHK("unmapped", 8'h00, rd)
        rawWr(ADDR_DATA_PATH_CONFIG, 8'hFF);
        rawRd(ADDR_DATA_PATH_CONFIG, rd);
        `CHK("data config", 8'h07, rd)
        for (int i = 0; i < 4; i++) begin
            x = roll();
            rawWr(ADDR_BLOCK_INPUT + 8'(i % 2), x);
            rawRd(ADDR_BLOCK_INPUT + 8'(i % 2), rd);
            `CHK("readback", x, rd)
        end
        $display("test registers done");
        rawWr(ADDR_IRQ_MASK, 8'h01);
        for (int t = 0; t < 4; t++) begin
            runOp(!t[0], 2'(t % 3), t == 3);
            $display("test operation %0d done", t);
        end
        endSim();
    end
endmodule
`default_nettype wire
